/* File: verilog/uart_lsr_pkg.sv */
package uart_lsr_pkg;
  // register byte addresses
  localparam logic [31:0] RBR_OFS  = 32'h5000_1100;
  localparam logic [31:0] THR_OFS  = 32'h5000_1100;
  localparam logic [31:0] CTRL_OFS = 32'h5000_1108;
  localparam logic [31:0] LSR_OFS  = 32'h5000_1114;
  // line_status bit positions
  localparam int DR_B   = 0;
  localparam int OE_B   = 1;
  localparam int PE_B   = 2;
  localparam int FE_B   = 3;
  localparam int BI_B   = 4;
  localparam int THRE_B = 5;
  localparam int TEMT_B = 6;
  localparam int RFE_B  = 7;
  localparam logic [15:0] LSR_RST = 16'h0060;
  // control register fields
  localparam int C_FEN  = 0;
  localparam int C_TMOD = 1;
  localparam int C_TLVL = 2;
  localparam int C_PEN  = 4;
  localparam int C_ODD  = 5;
  localparam int C_IR   = 6;
  localparam int C_THIE = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // tx threshold codes
  localparam logic [1:0] TL_EMPTY = 2'h0;
  localparam logic [1:0] TL_TWO   = 2'h1;
  localparam logic [1:0] TL_QTR   = 2'h2;
  // receiver timing, in sample ticks (16 per bit)
  localparam int          CHAR_BITS = 8;
  localparam int          OVS       = 16;
  localparam logic [3:0]  HALF_TICK = 4'h7;
  localparam logic [3:0]  LAST_TICK = 4'hF;
  localparam logic [7:0]  CHAR_NP   = 8'((CHAR_BITS + 2) * OVS);
  localparam logic [7:0]  CHAR_PAR  = 8'((CHAR_BITS + 3) * OVS);
  typedef enum logic [5:0] {
    RX_IDLE  = 6'h01,
    RX_START = 6'h02,
    RX_DATA  = 6'h04,
    RX_PAR   = 6'h08,
    RX_STOP  = 6'h10,
    RX_BRK   = 6'h20
  } rx_state_t;
  typedef struct packed {
    logic        bi;
    logic        fe;
    logic        pe;
    logic [7:0]  data;
  } rx_entry_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;
endpackage : uart_lsr_pkg

/* File: verilog/uart_line_status.sv */
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
module uart_line_status import uart_lsr_pkg::*; #(
  parameter int RX_DEPTH = 16,
  parameter int TX_DEPTH = 16
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire bus_req_t    bus,
  output logic [31:0]      rd_data_r,
  input  wire logic        sample_tick,
  input  wire logic        serial_in,
  input  wire logic        infrared_serial_in,
  input  wire logic        tx_shift_empty,
  output logic             tx_load_r,
  output logic [7:0]       tx_data_r,
  output logic             holding_empty_req_r
);
  localparam int RAW = $clog2(RX_DEPTH);
  localparam int TAW = $clog2(TX_DEPTH);
  localparam logic [RAW:0] RX_FULL = RX_DEPTH[RAW:0];
  localparam logic [TAW:0] TX_FULL = TX_DEPTH[TAW:0];
  localparam logic [TAW:0] TX_QTR  = TX_FULL >> 2;
  localparam logic [TAW:0] TX_HALF = TX_FULL >> 1;

  // bus decode
  wire lsr_rd  = bus.rd && bus.addr == LSR_OFS;
  wire rbr_rd  = bus.rd && bus.addr == RBR_OFS;
  wire thr_wr  = bus.wr && bus.addr == THR_OFS;
  wire ctrl_wr = bus.wr && bus.addr == CTRL_OFS;

  logic [7:0] ctrl_r;                 // mode and format controls
  wire fifo_en = ctrl_r[C_FEN];
  wire tmode   = ctrl_r[C_TMOD];
  wire parity_enable     = ctrl_r[C_PEN];
  wire ir_mode = ctrl_r[C_IR];
  // toggling fifo enable empties both queues
  wire flush   = ctrl_wr && bus.wdata[C_FEN] != fifo_en;

  // ---------------- receive line ----------------
  logic [3:0]  ir_hold_r;             // stretches short ir pulses
  rx_state_t   rx_state_r;
  logic [3:0]  tick_cnt_r;            // sixteenth of a bit
  logic [3:0]  bit_cnt_r;
  logic [7:0]  shift_r;
  logic        par_bit_r;
  logic [7:0]  low_cnt_r;             // ticks of continuous low

  // each ir low pulse counts as a low bit time
  wire ir_line = !(ir_hold_r != 4'h0 || !infrared_serial_in);
  wire rx_line = ir_mode ? ir_line : serial_in;
  wire mid_w   = sample_tick && tick_cnt_r == HALF_TICK;
  wire end_w   = sample_tick && tick_cnt_r == LAST_TICK;
  wire [7:0] char_ticks = parity_enable ? CHAR_PAR : CHAR_NP;
  wire brk_cand = shift_r == 8'h00 && !par_bit_r;
  wire in_stop  = rx_state_r == RX_STOP;
  wire in_brk   = rx_state_r == RX_BRK;

  // character completion events
  wire stop_push = in_stop && end_w && (rx_line || !brk_cand);
  // low outlasted a whole character: break, pushed once
  wire brk_push  = in_brk && sample_tick && !rx_line
                   && low_cnt_r == char_ticks;
  // line rose before break length: plain framing error
  wire brkfe_push = in_brk && rx_line && low_cnt_r <= char_ticks;
  wire push = stop_push || brk_push || brkfe_push;
  wire par_bad = parity_enable && ((^{shift_r, par_bit_r}) ^ ctrl_r[C_ODD]);

  rx_entry_t ent;
  assign ent.data = brk_push ? 8'h00 : shift_r;
  assign ent.bi   = brk_push;
  assign ent.fe   = brk_push || brkfe_push
                    || (stop_push && !rx_line);
  assign ent.pe   = brk_push || par_bad;
  wire ent_err = ent.bi || ent.fe || ent.pe;

  // ir pulse stretcher
  always_ff @(posedge clk) begin
    if (sys_rst)
      ir_hold_r <= 4'h0;
    else if (!infrared_serial_in)
      ir_hold_r <= LAST_TICK;
    else if (sample_tick && ir_hold_r != 4'h0)
      ir_hold_r <= ir_hold_r - 4'h1;
  end

  // low-time counter, saturating
  always_ff @(posedge clk) begin
    if (sys_rst || rx_line)
      low_cnt_r <= 8'h00;
    else if (sample_tick && low_cnt_r != 8'hFF)
      low_cnt_r <= low_cnt_r + 8'h01;
  end

  // receiver sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_state_r <= RX_IDLE;
      tick_cnt_r <= 4'h0;
      bit_cnt_r  <= 4'h0;
      shift_r    <= 8'h00;
      par_bit_r  <= 1'b0;
    end else begin
      if (sample_tick)
        tick_cnt_r <= tick_cnt_r + 4'h1;
      unique case (rx_state_r)
        RX_IDLE: begin
          tick_cnt_r <= 4'h0;
          if (sample_tick && !rx_line)
            rx_state_r <= RX_START;
        end
        RX_START: begin
          // a glitch shorter than half a bit is dropped
          if (mid_w) begin
            tick_cnt_r <= 4'h0;
            bit_cnt_r  <= 4'h0;
            par_bit_r  <= 1'b0;
            rx_state_r <= rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (end_w) begin
            shift_r   <= {rx_line, shift_r[7:1]};
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == 4'(CHAR_BITS - 1))
              rx_state_r <= parity_enable ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: begin
          if (end_w) begin
            par_bit_r  <= rx_line;
            rx_state_r <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (end_w) begin
            if (rx_line) begin
              rx_state_r <= RX_IDLE;
            end else if (brk_cand) begin
              rx_state_r <= RX_BRK;
            end else begin
              // low stop bit doubles as next start bit
              bit_cnt_r  <= 4'h0;
              par_bit_r  <= 1'b0;
              rx_state_r <= RX_DATA;
            end
          end
        end
        RX_BRK: begin
          // wait for the line to return high
          if (rx_line)
            rx_state_r <= RX_IDLE;
        end
      endcase
    end
  end

  // ---------------- receive queue ----------------
  rx_entry_t      rx_mem [RX_DEPTH];  // also the single buffer
  logic [RAW-1:0] rx_wp_r;
  logic [RAW-1:0] rx_rp_r;
  logic [RAW:0]   rx_cnt_r;
  logic [RAW:0]   err_cnt_r;          // queued characters with errors
  logic           shown_r;            // head flags already revealed
  logic [3:0]     flags_r;            // bi fe pe oe
  logic           rfe_r;

  rx_entry_t head;
  assign head = rx_mem[rx_rp_r];
  wire head_err = head.bi || head.fe || head.pe;
  wire rx_full  = rx_cnt_r == RX_FULL;
  wire rx_any   = rx_cnt_r != '0;
  wire pop      = rbr_rd && rx_any;
  // fifo full drops the char; single buffer gets overwritten
  wire push_ok  = push && !(fifo_en && rx_full);
  wire ovr_evt  = push && (fifo_en ? rx_full : rx_any);
  wire reveal   = fifo_en && rx_any && !shown_r;
  wire [3:0] set_vec = fifo_en
      ? {reveal && head.bi, reveal && head.fe, reveal && head.pe, ovr_evt}
      : {push && ent.bi, push && ent.fe, push && ent.pe, ovr_evt};
  wire rfe_set = fifo_en && push_ok && ent_err;
  wire rfe_clr = lsr_rd && (err_cnt_r == '0
                 || (err_cnt_r == 1 && head_err && rx_any));
  wire [RAW:0] err_up = {{RAW{1'b0}}, fifo_en && push_ok && ent_err};
  wire [RAW:0] err_dn = {{RAW{1'b0}}, fifo_en && pop && head_err};

  // queue storage
  always_ff @(posedge clk) begin
    if (push_ok)
      rx_mem[fifo_en ? rx_wp_r : '0] <= ent;
  end

  // queue pointers and counts
  always_ff @(posedge clk) begin
    if (sys_rst || flush) begin
      rx_wp_r   <= '0;
      rx_rp_r   <= '0;
      rx_cnt_r  <= '0;
      err_cnt_r <= '0;
    end else if (fifo_en) begin
      if (push_ok)
        rx_wp_r <= rx_wp_r + 1'b1;
      if (pop)
        rx_rp_r <= rx_rp_r + 1'b1;
      rx_cnt_r  <= rx_cnt_r + {{RAW{1'b0}}, push_ok} - {{RAW{1'b0}}, pop};
      err_cnt_r <= err_cnt_r + err_up - err_dn;
    end else begin
      // one-deep buffer: a new char wins over the read
      if (push)
        rx_cnt_r <= {{RAW{1'b0}}, 1'b1};
      else if (pop)
        rx_cnt_r <= '0;
    end
  end

  // error flags: hardware set wins over read clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_r <= 4'h0;
      rfe_r   <= 1'b0;
      shown_r <= 1'b0;
    end else begin
      flags_r <= set_vec | (flags_r & ~{4{lsr_rd}});
      rfe_r   <= !flush && fifo_en && (rfe_set || (rfe_r && !rfe_clr));
      shown_r <= !(flush || pop) && (shown_r || reveal);
    end
  end

  // ---------------- transmit side ----------------
  logic [7:0]     tx_mem [TX_DEPTH];
  logic [TAW-1:0] tx_wp_r;
  logic [TAW-1:0] tx_rp_r;
  logic [TAW:0]   tx_cnt_r;
  logic           temt_r;

  wire [TAW:0] tx_cap = fifo_en ? TX_FULL : {{TAW{1'b0}}, 1'b1};
  wire tx_push  = thr_wr && tx_cnt_r != tx_cap;   // full: write dropped
  wire tx_pop   = tx_cnt_r != '0 && tx_shift_empty && !tx_load_r;
  wire thr_mode = tmode && fifo_en;
  // holding empty, or fifo full in threshold mode
  wire thre     = thr_mode ? tx_cnt_r == TX_FULL
                           : tx_cnt_r == '0;
  logic [TAW:0] tx_lvl;
  always_comb begin
    unique case (ctrl_r[C_TLVL +: 2])
      TL_EMPTY: tx_lvl = '0;
      TL_TWO:   tx_lvl = (TAW+1)'(2);
      TL_QTR:   tx_lvl = TX_QTR;
      default:  tx_lvl = TX_HALF;
    endcase
  end
  wire thr_req = thr_mode ? tx_cnt_r <= tx_lvl : thre;

  // transmit storage
  always_ff @(posedge clk) begin
    if (tx_push)
      tx_mem[tx_wp_r] <= bus.wdata[7:0];
  end

  // transmit pointers and hand-off to the shifter
  always_ff @(posedge clk) begin
    if (sys_rst || flush) begin
      tx_wp_r  <= '0;
      tx_rp_r  <= '0;
      tx_cnt_r <= '0;
    end else begin
      if (tx_push)
        tx_wp_r <= tx_wp_r + 1'b1;
      if (tx_pop)
        tx_rp_r <= tx_rp_r + 1'b1;
      tx_cnt_r <= tx_cnt_r + {{TAW{1'b0}}, tx_push} - {{TAW{1'b0}}, tx_pop};
    end
  end

  // outputs to shifter and interrupt logic
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_load_r           <= 1'b0;
      tx_data_r           <= 8'h00;
      temt_r              <= 1'b1;
      holding_empty_req_r <= 1'b0;
    end else begin
      tx_load_r <= tx_pop;
      if (tx_pop)
        tx_data_r <= tx_mem[tx_rp_r];
      // load pulse still in flight counts as busy
      temt_r <= tx_cnt_r == '0 && tx_shift_empty && !tx_load_r;
      holding_empty_req_r <= ctrl_r[C_THIE] && thr_req;
    end
  end

  // ---------------- registers ----------------
  wire [15:0] lsr = {8'h00, rfe_r, temt_r, thre, flags_r, rx_any};
  wire [31:0] rd_mux = lsr_rd ? {16'h0000, lsr}
                     : rbr_rd ? {24'h000000, head.data}
                     : (bus.rd && bus.addr == CTRL_OFS) ? {24'h000000, ctrl_r}
                     : 32'h0000_0000;

  // control write; line_status has no write path
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r    <= CTRL_RST;
      rd_data_r <= 32'h0000_0000;
    end else begin
      if (ctrl_wr)
        ctrl_r <= bus.wdata[7:0];
      rd_data_r <= rd_mux;
    end
  end

  // ---------------- checks ----------------
  a_reset_status: assert property (@(posedge clk)
    sys_rst |=> lsr == LSR_RST)
    else $error("status not at reset value");
  a_fifo_overrun: assert property (@(posedge clk) disable iff (sys_rst)
    fifo_en && push && rx_full && !flush |=> flags_r[0]
      && rx_cnt_r == $past(rx_cnt_r) - ($past(pop) ? 1 : 0))
    else $error("fifo overrun not handled");
  a_buf_overrun: assert property (@(posedge clk) disable iff (sys_rst)
    !fifo_en && !ctrl_wr && push && rx_any |=> flags_r[0]
      && head.data == $past(ent.data))
    else $error("buffer overrun not handled");
  a_lsr_clear: assert property (@(posedge clk) disable iff (sys_rst)
    lsr_rd && set_vec == 4'h0 |=> flags_r == 4'h0)
    else $error("read did not clear flags");
  a_lsr_nowrite: assert property (@(posedge clk) disable iff (sys_rst)
    bus.wr && bus.addr == LSR_OFS && set_vec == 4'h0
      |=> flags_r == $past(flags_r) && ctrl_r == $past(ctrl_r))
    else $error("write altered status");
  a_break_char: assert property (@(posedge clk) disable iff (sys_rst)
    push && ent.bi |-> ent.fe && ent.pe && ent.data == 8'h00
      && low_cnt_r == char_ticks)
    else $error("bad break character");
  a_break_once: assert property (@(posedge clk) disable iff (sys_rst)
    push && ent.bi |=> !(push && ent.bi) [*8])
    else $error("second break character");
  a_resync: assert property (@(posedge clk) disable iff (sys_rst)
    in_stop && end_w && !rx_line && !brk_cand
      |=> rx_state_r == RX_DATA && bit_cnt_r == 4'h0)
    else $error("no resync after framing error");
  a_head_reveal: assert property (@(posedge clk) disable iff (sys_rst)
    reveal && head.fe |=> flags_r[2])
    else $error("head framing error hidden");
  a_rfe_hold: assert property (@(posedge clk) disable iff (sys_rst)
    fifo_en && !flush && (rfe_set || (lsr_rd && err_cnt_r > 1))
      |=> rfe_r)
    else $error("fifo error flag lost");
  a_temt_busy: assert property (@(posedge clk) disable iff (sys_rst)
    tx_cnt_r != '0 |=> !temt_r)
    else $error("transmitter empty while queued");
  a_thre_mode: assert property (@(posedge clk) disable iff (sys_rst)
    thr_mode && tx_push && !tx_pop && tx_cnt_r == TX_FULL - 1 |=> lsr[THRE_B])
    else $error("full not reported");
  a_data_ready: assert property (@(posedge clk) disable iff (sys_rst)
    !fifo_en && rbr_rd && !push && !ctrl_wr |=> !lsr[DR_B])
    else $error("data ready not cleared");
  c_break: cover property (@(posedge clk) push && ent.bi);
  c_overrun: cover property (@(posedge clk) fifo_en && ovr_evt);
  c_rfe: cover property (@(posedge clk) rfe_r && lsr_rd);
  c_ir_break: cover property (@(posedge clk) ir_mode && brk_push);
endmodule : uart_line_status

/* File: tb/serial_peer.sv */
`timescale 1ns/100ps
// remote serial peer plus a stand-in for the transmit shifter
module serial_peer #(
  parameter int BIT_CYC   = 32,  // 16 ticks, one tick every two cycles
  parameter int SHIFT_CYC = 40   // shifter busy time per word
) (
  input  wire logic       clk,
  input  wire logic       tx_load,
  input  wire logic [7:0] tx_data,
  output logic            sample_tick,
  output logic            serial_in,
  output logic            infrared_serial_in,
  output logic            tx_shift_empty
);
  int         busy_cnt  = 0;     // shifter cycles left
  int         n_loads   = 0;     // words taken from the block
  logic [7:0] last_data = 8'h00; // last word shifted out
  logic       stall     = 1'b0;  // holds the shifter busy on demand
  // lines idle high, the shifter starts idle
  initial begin
    sample_tick = 1'b0;
    serial_in = 1'b1;
    infrared_serial_in = 1'b1;
    tx_shift_empty = 1'b1;
  end
  // tick at half the clock rate
  always @(posedge clk) begin
    sample_tick <= ~sample_tick;
  end
  // shifter: busy for a while after each load, or while stalled
  always @(posedge clk) begin
    if (tx_load) begin
      busy_cnt  <= SHIFT_CYC;
      n_loads   <= n_loads + 1;
      last_data <= tx_data;
    end else if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
    end
    tx_shift_empty <= !stall && !tx_load && busy_cnt <= 1;
  end
  // one bit cell on the plain line
  task automatic send_bit(input logic b);
    serial_in <= b;
    repeat (BIT_CYC) @(posedge clk);
  endtask : send_bit
  // lsb first; a bad stop bit runs straight into what follows
  task automatic send_frame(input logic [7:0] d, input logic start, input logic par_on,
                            input logic par, input logic stop);
    if (start) send_bit(1'b0);
    for (int i = 0; i < 8; i++) send_bit(d[i]);
    if (par_on) send_bit(par);
    send_bit(stop);
    if (stop) send_bit(1'b1);
  endtask : send_frame
  // line held low for whole bit cells
  task automatic send_break(input int nbits);
    repeat (nbits) send_bit(1'b0);
    repeat (2) send_bit(1'b1);
  endtask : send_break
  // short low pulse in every cell, as an infrared zero
  task automatic ir_break(input int nbits);
    repeat (nbits) begin
      infrared_serial_in <= 1'b0;
      repeat (4) @(posedge clk);
      infrared_serial_in <= 1'b1;
      repeat (BIT_CYC - 4) @(posedge clk);
    end
    repeat (2 * BIT_CYC) @(posedge clk);
  endtask : ir_break
endmodule : serial_peer

/* File: tb/uart_line_status_tb_top.sv */
`timescale 1ns/100ps
module uart_line_status_tb_top import uart_lsr_pkg::*;;
  localparam logic [31:0] UNMAPPED = 32'h5000_1120; // no register here
  logic        clk;
  logic        sys_rst;
  bus_req_t    bus;
  logic [31:0] rd_data_r;
  logic        sample_tick, serial_in, infrared_serial_in, tx_shift_empty;
  logic        tx_load_r, holding_empty_req_r;
  logic [7:0]  tx_data_r;
  int          errors = 0;
  int          n_compared = 0;

  uart_line_status dut (.clk(clk), .sys_rst(sys_rst), .bus(bus), .rd_data_r(rd_data_r),
    .sample_tick(sample_tick), .serial_in(serial_in),
    .infrared_serial_in(infrared_serial_in), .tx_shift_empty(tx_shift_empty),
    .tx_load_r(tx_load_r), .tx_data_r(tx_data_r),
    .holding_empty_req_r(holding_empty_req_r));
  serial_peer peer (.clk(clk), .tx_load(tx_load_r), .tx_data(tx_data_r),
    .sample_tick(sample_tick), .serial_in(serial_in),
    .infrared_serial_in(infrared_serial_in), .tx_shift_empty(tx_shift_empty));

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one-cycle strobes, changed just after the edge
  task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : bus_wr
  // data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 check(what, exp, rd_data_r);
  endtask : rd_chk
  // bounded wait for shifter loads; running out ends the run
  task automatic wait_loads(input int n);
    int k;
    k = 0;
    while (peer.n_loads < n && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 3000) begin
      errors++;
      end_of_test();
    end
  endtask : wait_loads

  task automatic t_reset();
    rd_chk("status", LSR_OFS, 32'h0000_0060);
    bus_wr(LSR_OFS, 32'h0000_FFFF);
    rd_chk("status", LSR_OFS, 32'h0000_0060);
    rd_chk("unmapped", UNMAPPED, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset

  // second char before the buffer is read
  task automatic t_rx_plain();
    peer.send_frame(8'h11, 1'b1, 1'b0, 1'b0, 1'b1);
    rd_chk("status", LSR_OFS, 32'h0000_0061);
    peer.send_frame(8'h22, 1'b1, 1'b0, 1'b0, 1'b1);
    rd_chk("status", LSR_OFS, 32'h0000_0063);
    rd_chk("rx", RBR_OFS, 32'h0000_0022);
    rd_chk("status", LSR_OFS, 32'h0000_0060);
    $display("test rx plain done");
  endtask : t_rx_plain

  task automatic t_parity();
    bus_wr(CTRL_OFS, 32'h0000_0010);
    peer.send_frame(8'h5A, 1'b1, 1'b1, ~(^8'h5A), 1'b1);
    rd_chk("status", LSR_OFS, 32'h0000_0065);
    rd_chk("rx", RBR_OFS, 32'h0000_005A);
    rd_chk("status", LSR_OFS, 32'h0000_0060);
    bus_wr(CTRL_OFS, 32'h0000_0030);
    peer.send_frame(8'h5A, 1'b1, 1'b1, ~(^8'h5A), 1'b1);
    rd_chk("status", LSR_OFS, 32'h0000_0061);
    rd_chk("rx", RBR_OFS, 32'h0000_005A);
    bus_wr(CTRL_OFS, 32'h0000_0000);
    $display("test parity done");
  endtask : t_parity

  // low stop bit, then data bits with no start bit of their own
  task automatic t_frame();
    peer.send_frame(8'h3C, 1'b1, 1'b0, 1'b0, 1'b0);
    peer.send_frame(8'hC3, 1'b0, 1'b0, 1'b0, 1'b1);
    rd_chk("status", LSR_OFS, 32'h0000_006B);
    rd_chk("rx", RBR_OFS, 32'h0000_00C3);
    rd_chk("status", LSR_OFS, 32'h0000_0060);
    $display("test framing done");
  endtask : t_frame

  task automatic t_break();
    peer.send_break(12);
    rd_chk("status", LSR_OFS, 32'h0000_007D);
    rd_chk("rx", RBR_OFS, 32'h0000_0000);
    rd_chk("status", LSR_OFS, 32'h0000_0060);
    $display("test break done");
  endtask : t_break

  // ir pulses ignored in plain mode, a break in infrared mode
  task automatic t_ir();
    peer.ir_break(12);
    rd_chk("status", LSR_OFS, 32'h0000_0060);
    bus_wr(CTRL_OFS, 32'h0000_0040);
    peer.ir_break(12);
    rd_chk("status", LSR_OFS, 32'h0000_007D);
    rd_chk("rx", RBR_OFS, 32'h0000_0000);
    rd_chk("status", LSR_OFS, 32'h0000_0060);
    bus_wr(CTRL_OFS, 32'h0000_0000);
    $display("test infrared done");
  endtask : t_ir

  // error char behind a good one, then overfill the queue
  task automatic t_fifo();
    bus_wr(CTRL_OFS, 32'h0000_0011);
    peer.send_frame(8'h01, 1'b1, 1'b1, ^8'h01, 1'b1);
    peer.send_frame(8'h02, 1'b1, 1'b1, ~(^8'h02), 1'b1);
    peer.send_frame(8'h03, 1'b1, 1'b1, ^8'h03, 1'b1);
    rd_chk("status", LSR_OFS, 32'h0000_00E1);
    rd_chk("rx", RBR_OFS, 32'h0000_0001);
    rd_chk("status", LSR_OFS, 32'h0000_00E5);
    rd_chk("rx", RBR_OFS, 32'h0000_0002);
    rd_chk("status", LSR_OFS, 32'h0000_0061);
    rd_chk("rx", RBR_OFS, 32'h0000_0003);
    rd_chk("status", LSR_OFS, 32'h0000_0060);
    for (int i = 0; i < 17; i++) peer.send_frame(8'(8'h40 + i), 1'b1, 1'b1, ^8'(8'h40 + i), 1'b1);
    rd_chk("status", LSR_OFS, 32'h0000_0063);
    for (int i = 0; i < 16; i++) rd_chk("rx", RBR_OFS, 32'(8'h40 + i));
    rd_chk("status", LSR_OFS, 32'h0000_0060);
    // good char, then a break carried through the queue to the head
    peer.send_frame(8'h55, 1'b1, 1'b1, ^8'h55, 1'b1);
    peer.send_break(12);
    rd_chk("status", LSR_OFS, 32'h0000_00E1);
    rd_chk("rx", RBR_OFS, 32'h0000_0055);
    rd_chk("status", LSR_OFS, 32'h0000_00FD);
    rd_chk("rx", RBR_OFS, 32'h0000_0000);
    rd_chk("status", LSR_OFS, 32'h0000_0060);
    bus_wr(CTRL_OFS, 32'h0000_0000);
    $display("test fifo done");
  endtask : t_fifo

  task automatic t_tx_plain();
    int n0;
    n0 = peer.n_loads;
    bus_wr(CTRL_OFS, 32'h0000_0080);
    bus_wr(THR_OFS, 32'h0000_0081);
    wait_loads(n0 + 1);
    rd_chk("status", LSR_OFS, 32'h0000_0020);
    check("req", 32'h1, {31'h0, holding_empty_req_r});
    check("tx data", 32'h81, {24'h0, peer.last_data});
    repeat (60) @(posedge clk);
    rd_chk("status", LSR_OFS, 32'h0000_0060);
    $display("test tx plain done");
  endtask : t_tx_plain

  // shifter stalled while the queue fills; one word too many
  task automatic t_tx_fifo();
    int n0;
    n0 = peer.n_loads;
    peer.stall = 1'b1;
    bus_wr(CTRL_OFS, 32'h0000_0083);
    for (int i = 0; i < 17; i++) bus_wr(THR_OFS, 32'(8'h90 + i));
    rd_chk("status", LSR_OFS, 32'h0000_0020);
    check("req", 32'h0, {31'h0, holding_empty_req_r});
    peer.stall = 1'b0;
    wait_loads(n0 + 16);
    repeat (60) @(posedge clk);
    rd_chk("status", LSR_OFS, 32'h0000_0040);
    check("req", 32'h1, {31'h0, holding_empty_req_r});
    check("loads", 32'd16, 32'(peer.n_loads - n0));
    check("tx data", 32'h9F, {24'h0, peer.last_data});
    $display("test tx fifo done");
  endtask : t_tx_fifo

  // request settles one edge after the level changes
  task automatic req_chk(input logic exp);
    repeat (2) @(posedge clk);
    #1 check("req", {31'h0, exp}, {31'h0, holding_empty_req_r});
  endtask : req_chk

  // stalled shifter: request against the two, quarter and half threshold levels
  task automatic t_tx_level();
    int n0;
    n0 = peer.n_loads;
    peer.stall = 1'b1;
    bus_wr(CTRL_OFS, 32'h0000_0087);
    bus_wr(THR_OFS, 32'h0000_00A0);
    bus_wr(THR_OFS, 32'h0000_00A1);
    req_chk(1'b1);
    bus_wr(THR_OFS, 32'h0000_00A2);
    req_chk(1'b0);
    bus_wr(CTRL_OFS, 32'h0000_008B);
    req_chk(1'b1);
    bus_wr(THR_OFS, 32'h0000_00A3);
    bus_wr(THR_OFS, 32'h0000_00A4);
    req_chk(1'b0);
    bus_wr(CTRL_OFS, 32'h0000_008F);
    req_chk(1'b1);
    peer.stall = 1'b0;
    wait_loads(n0 + 5);
    check("tx data", 32'hA4, {24'h0, peer.last_data});
    $display("test tx level done");
  endtask : t_tx_level

  // main sequence
  initial begin
    sys_rst = 1'b1;
    bus = '0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_rx_plain();
    t_parity();
    t_frame();
    t_break();
    t_ir();
    t_fifo();
    t_tx_plain();
    t_tx_fifo();
    t_tx_level();
    end_of_test();
  end

  // hang guard
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    end_of_test();
  end
endmodule : uart_line_status_tb_top
